// ==== src/mie_move_exec.sv ====
// Data-move execution block with an AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "mie_regs.svh"
module mie_move_exec import mie_pkg::*; (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [`MIE_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [`MIE_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic [7:0] ACC_OUT,
    output logic ZERO_OUT,
    output logic [`MIE_BANK_W-1:0] BANK_OUT,
    output logic [`MIE_LATCH_W-1:0] LATCH_OUT
);
    // ============================================================
    // Helper functions

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Known register offset check, used for reads and writes
    function automatic logic mapped(input logic [`MIE_ADDR_W-1:0] a);
        return (a == `MIE_OFF_INSTR) || (a == `MIE_OFF_ACC) ||
               (a == `MIE_OFF_STATUS) || (a == `MIE_OFF_BANK) ||
               (a == `MIE_OFF_LATCH) || (a == `MIE_OFF_PTR0) ||
               (a == `MIE_OFF_PTR1) || (a == `MIE_OFF_MEMADDR) ||
               (a == `MIE_OFF_MEMDATA);
    endfunction

    // ============================================================
    // State
    logic aw_got_reg; // Write address held
    logic [`MIE_ADDR_W-1:0] aw_addr_reg; // Held write address
    logic w_got_reg; // Write data held
    logic [31:0] w_data_reg; // Held write data
    logic [3:0] w_strb_reg; // Held byte strobes
    logic [7:0] acc_reg; // Accumulator
    logic zero_reg; // Zero flag
    logic [`MIE_BANK_W-1:0] bank_reg; // Bank select
    logic [`MIE_LATCH_W-1:0] latch_reg; // Program counter high latch
    logic [`MIE_PTR_W-1:0] ptr_reg [0:1]; // Two indirect pointers
    logic [`MIE_MEM_AW-1:0] mem_addr_reg; // Software memory index
    logic [7:0] mem [0:`MIE_MEM_DEPTH-1]; // Data space, no reset

    // ============================================================
    // Write decode
    logic wr_fire; // Both halves held, response free
    logic wr_ok; // Address maps to a register
    logic wr_instr; // Execute an instruction
    logic wr_acc; // Software loads accumulator
    logic wr_memaddr; // Software moves memory index
    logic wr_memdata; // Software writes data space
    logic [1:0] wr_ptr; // Software writes a pointer

    assign wr_fire = aw_got_reg & w_got_reg & ~BVALID;
    assign wr_ok = mapped(aw_addr_reg);
    // Any strobe pattern issues the instruction as written
    assign wr_instr = wr_fire & (aw_addr_reg == `MIE_OFF_INSTR);
    assign wr_acc = wr_fire & (aw_addr_reg == `MIE_OFF_ACC);
    assign wr_memaddr = wr_fire & (aw_addr_reg == `MIE_OFF_MEMADDR);
    assign wr_memdata = wr_fire & (aw_addr_reg == `MIE_OFF_MEMDATA);
    assign wr_ptr[0] = wr_fire & (aw_addr_reg == `MIE_OFF_PTR0);
    assign wr_ptr[1] = wr_fire & (aw_addr_reg == `MIE_OFF_PTR1);

    // ============================================================
    // Instruction fields
    mie_op_t op; // Operation
    logic dest; // Target choice bit
    logic sel; // Pointer select
    mie_mode_t mode; // Pointer update mode
    logic rel; // Relative-offset form
    logic [7:0] lit; // Literal byte
    logic [`MIE_FILE_W-1:0] file; // File register address
    logic [`MIE_OFS_W-1:0] ofs; // Signed offset

    assign op = mie_op_t'(w_data_reg[`MIE_F_OP_HI:`MIE_F_OP_LO]);
    assign dest = w_data_reg[`MIE_F_DEST];
    assign sel = w_data_reg[`MIE_F_SEL];
    assign mode = mie_mode_t'(w_data_reg[`MIE_F_MODE_HI:`MIE_F_MODE_LO]);
    assign rel = w_data_reg[`MIE_F_REL];
    assign lit = w_data_reg[`MIE_F_LIT_HI:`MIE_F_LIT_LO];
    assign file = w_data_reg[`MIE_F_FILE_HI:`MIE_F_LIT_LO];
    assign ofs = w_data_reg[`MIE_F_OFS_HI:`MIE_F_LIT_LO];

    // ============================================================
    // Per-operation strobes, each acts in the single issue cycle
    logic do_mov; // Move register
    logic do_il; // Indirect load
    logic do_lb; // Load bank
    logic do_lp; // Load latch
    logic do_lw; // Load literal

    assign do_mov = wr_instr & (op == MIE_OP_MOVE_REG);
    assign do_il = wr_instr & (op == MIE_OP_IND_LOAD);
    assign do_lb = wr_instr & (op == MIE_OP_LOAD_BANK);
    assign do_lp = wr_instr & (op == MIE_OP_LOAD_LATCH);
    assign do_lw = wr_instr & (op == MIE_OP_LOAD_LIT);

    // ============================================================
    // Address formation
    logic is_win; // File address is a window register
    logic [`MIE_PTR_W-1:0] direct_addr; // Banked direct address
    logic [`MIE_PTR_W-1:0] mv_addr; // Move-register data address
    logic [`MIE_PTR_W-1:0] il_addr; // Indirect-load address
    logic [`MIE_PTR_W-1:0] il_ptr; // Pointer after indirect load
    logic [7:0] mv_data; // Value moved by move register
    logic [7:0] il_data; // Value moved by indirect load

    // Window registers hold no storage; they stand for the pointee
    assign is_win = (file == `MIE_WIN0_ADDR) ||
                    (file == `MIE_WIN1_ADDR);
    assign direct_addr = {{(`MIE_PTR_W-`MIE_BANK_W-`MIE_FILE_W){1'b0}},
                          bank_reg, file};
    assign mv_addr = is_win ? ptr_reg[file[0]] : direct_addr;
    // Only the low address bits reach the data array
    assign mv_data = mem[mv_addr[`MIE_MEM_AW-1:0]];
    assign il_data = mem[il_addr[`MIE_MEM_AW-1:0]];

    // Pointer arithmetic for the selected pointer
    mie_ptr_unit u_ptr (
        .ptr(ptr_reg[sel]),
        .mode(mode),
        .rel(rel),
        .offset(ofs),
        .acc_addr(il_addr),
        .ptr_new(il_ptr)
    );

    // ============================================================
    // Next values of core registers
    logic [7:0] acc_next; // Accumulator next
    logic zero_next; // Zero flag next
    logic [`MIE_BANK_W-1:0] bank_next; // Bank next
    logic [`MIE_LATCH_W-1:0] latch_next; // Latch next
    logic [`MIE_PTR_W-1:0] ptr_next [0:1]; // Pointers next
    logic [31:0] acc_sw; // Software-merged accumulator
    logic [31:0] mem_sw; // Software-merged data byte

    logic [31:0] mem_addr_sw; // Software-merged memory index
    assign acc_sw = merge({24'h000000, acc_reg}, w_data_reg, w_strb_reg);
    assign mem_addr_sw = merge({24'h000000, mem_addr_reg}, w_data_reg,
                               w_strb_reg);
    assign mem_sw = merge({24'h000000, mem[mem_addr_reg]}, w_data_reg,
                          w_strb_reg);

    // Accumulator takes moved data, loaded data or the literal
    assign acc_next = (do_mov & ~dest) ? mv_data :
                      do_il ? il_data :
                      do_lw ? lit :
                      wr_acc ? acc_sw[7:0] : acc_reg;
    // Zero flag follows both targets of move register
    assign zero_next = do_mov ? (mv_data == 8'h00) :
                       do_il ? (il_data == 8'h00) :
                       zero_reg;
    // Only the low five literal bits fit the bank register
    assign bank_next = do_lb ? lit[`MIE_BANK_W-1:0] : bank_reg;
    assign latch_next = do_lp ? lit[`MIE_LATCH_W-1:0]
                              : latch_reg;

    // Each pointer keeps its adjusted value, or takes a software write
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            logic [31:0] ptr_sw; // Software-merged pointer
            assign ptr_sw = merge({16'h0000, ptr_reg[gi]}, w_data_reg,
                                  w_strb_reg);
            assign ptr_next[gi] =
                (do_il & (sel == 1'(gi)) & ~rel) ? il_ptr :
                wr_ptr[gi] ? ptr_sw[`MIE_PTR_W-1:0] : ptr_reg[gi];
        end
    endgenerate

    // ============================================================
    // Core register update
    always_ff @(posedge CLK) begin
        if (SRST) begin
            acc_reg <= `MIE_ACC_RST;
            zero_reg <= 1'b0;
            bank_reg <= `MIE_BANK_RST;
            latch_reg <= `MIE_LATCH_RST;
            ptr_reg[0] <= `MIE_PTR_RST;
            ptr_reg[1] <= `MIE_PTR_RST;
            mem_addr_reg <= `MIE_MEMADDR_RST;
        end else begin
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            bank_reg <= bank_next;
            latch_reg <= latch_next;
            ptr_reg[0] <= ptr_next[0];
            ptr_reg[1] <= ptr_next[1];
            if (wr_memaddr) begin
                mem_addr_reg <= mem_addr_sw[`MIE_MEM_AW-1:0];
            end
        end
    end

    // ============================================================
    // Data space writes; a write-back stores the same byte it read
    always_ff @(posedge CLK) begin
        if (do_mov & dest) begin
            mem[mv_addr[`MIE_MEM_AW-1:0]] <= mv_data;
        end else if (wr_memdata) begin
            mem[mem_addr_reg] <= mem_sw[7:0];
        end
    end

    // ============================================================
    // Mirrored core outputs, one cycle behind the registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ACC_OUT <= `MIE_ACC_RST;
            ZERO_OUT <= 1'b0;
            BANK_OUT <= `MIE_BANK_RST;
            LATCH_OUT <= `MIE_LATCH_RST;
        end else begin
            ACC_OUT <= acc_reg;
            ZERO_OUT <= zero_reg;
            BANK_OUT <= bank_reg;
            LATCH_OUT <= latch_reg;
        end
    end

    // ============================================================
    // AXI write channels: address and data taken in any order
    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_got_reg <= 1'b0;
            aw_addr_reg <= {`MIE_ADDR_W{1'b0}};
            w_got_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= `MIE_RESP_OKAY;
        end else begin
            // Address: ready pulses once, then held until response
            if (AWVALID & AWREADY) begin
                AWREADY <= 1'b0;
                aw_got_reg <= 1'b1;
                aw_addr_reg <= AWADDR;
            end else if (AWVALID & ~aw_got_reg & ~BVALID) begin
                AWREADY <= 1'b1;
            end
            // Data channel mirrors the address channel
            if (WVALID & WREADY) begin
                WREADY <= 1'b0;
                w_got_reg <= 1'b1;
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
            end else if (WVALID & ~w_got_reg & ~BVALID) begin
                WREADY <= 1'b1;
            end
            // Response once both halves are in; unmapped gets SLVERR
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= wr_ok ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
            end else if (BVALID & BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // ============================================================
    // Read data selection
    logic [31:0] rd_mux; // Word for the read address

    assign rd_mux =
        (ARADDR == `MIE_OFF_ACC) ? {24'h000000, acc_reg} :
        (ARADDR == `MIE_OFF_STATUS) ? {31'h0, zero_reg} :
        (ARADDR == `MIE_OFF_BANK) ? {27'h0, bank_reg} :
        (ARADDR == `MIE_OFF_LATCH) ? {25'h0, latch_reg} :
        (ARADDR == `MIE_OFF_PTR0) ? {16'h0000, ptr_reg[0]} :
        (ARADDR == `MIE_OFF_PTR1) ? {16'h0000, ptr_reg[1]} :
        (ARADDR == `MIE_OFF_MEMADDR) ? {24'h000000, mem_addr_reg} :
        (ARADDR == `MIE_OFF_MEMDATA) ? {24'h000000, mem[mem_addr_reg]} :
        32'h00000000;

    // ============================================================
    // AXI read channel: ready one cycle, data the cycle after
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `MIE_RESP_OKAY;
        end else begin
            if (ARVALID & ARREADY) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= rd_mux;
                // Instruction register is write-only, reads as zero
                RRESP <= mapped(ARADDR) ? `MIE_RESP_OKAY
                                        : `MIE_RESP_SLVERR;
            end else begin
                if (ARVALID & ~RVALID) begin
                    ARREADY <= 1'b1;
                end
                if (RVALID & RREADY) begin
                    RVALID <= 1'b0;
                end
            end
        end
    end
endmodule // mie_move_exec
`default_nettype wire

// ==== src/mie_pkg.sv ====
// Types shared by the data-move execution block
package mie_pkg;

    // Operation codes of the instruction register
    typedef enum logic [2:0] {
        MIE_OP_NOP = 3'h0,
        MIE_OP_MOVE_REG = 3'h1,
        MIE_OP_IND_LOAD = 3'h2,
        MIE_OP_LOAD_BANK = 3'h3,
        MIE_OP_LOAD_LATCH = 3'h4,
        MIE_OP_LOAD_LIT = 3'h5
    } mie_op_t;

    // Pointer update modes
    typedef enum logic [1:0] {
        MIE_MODE_PRE_INC = 2'h0,
        MIE_MODE_PRE_DEC = 2'h1,
        MIE_MODE_POST_INC = 2'h2,
        MIE_MODE_POST_DEC = 2'h3
    } mie_mode_t;

endpackage

// ==== src/mie_ptr_unit.sv ====
// Pointer adjust unit: access address and updated pointer
`timescale 1ns/1ns
`default_nettype none
`include "mie_regs.svh"
module mie_ptr_unit import mie_pkg::*; (
    input wire logic [`MIE_PTR_W-1:0] ptr,
    input wire mie_mode_t mode,
    input wire logic rel,
    input wire logic [`MIE_OFS_W-1:0] offset,
    output logic [`MIE_PTR_W-1:0] acc_addr,
    output logic [`MIE_PTR_W-1:0] ptr_new
);
    // ============================================================
    // Step and offset
    logic [1:0] mode_bits; // Raw mode code
    logic [`MIE_PTR_W-1:0] step; // Plus or minus one
    logic [`MIE_PTR_W-1:0] adj; // Pointer after one step
    logic [`MIE_PTR_W-1:0] ofs_ext; // Sign-extended offset

    assign mode_bits = mode;
    // Bit 0 of the mode selects a decrement
    assign step = mode_bits[`MIE_MODE_DEC] ? `MIE_STEP_DEC
                                           : `MIE_STEP_INC;
    // Sixteen-bit add drops the carry, so the pointer wraps
    assign adj = ptr + step;
    assign ofs_ext = {{(`MIE_PTR_W-`MIE_OFS_W){offset[`MIE_OFS_W-1]}},
                      offset};

    // ============================================================
    // Address selection
    // Pre modes use the stepped value, post modes the old one
    assign acc_addr = rel ? ptr + ofs_ext
                    : (mode_bits[`MIE_MODE_POST] ? ptr : adj);
    // Relative form leaves the pointer as it was
    assign ptr_new = rel ? ptr : adj;
endmodule // mie_ptr_unit
`default_nettype wire

// ==== src/mie_regs.svh ====
// Constants for the data-move execution block: offsets, fields, resets
// ============================================================
// Function
// - Move register to accumulator or back
// - Move register updates zero flag always
// - Window register access goes through pointer
// - Indirect load to accumulator, updates zero
// - Mode 00 preinc 01 predec 10/11 post
// - Pre adjusts before access, post after
// - Relative form adds signed offset, pointer kept
// - Sixteen bit pointers wrap around
// - Load bank literal, flags unchanged
// - Load eight bit literal into accumulator
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH

// ============================================================
// Register byte offsets on the AXI4-Lite slave
`define MIE_ADDR_W 8
`define MIE_OFF_INSTR 8'h00
`define MIE_OFF_ACC 8'h04
`define MIE_OFF_STATUS 8'h08
`define MIE_OFF_BANK 8'h0c
`define MIE_OFF_LATCH 8'h10
`define MIE_OFF_PTR0 8'h14
`define MIE_OFF_PTR1 8'h18
`define MIE_OFF_MEMADDR 8'h1c
`define MIE_OFF_MEMDATA 8'h20

// ============================================================
// AXI responses
`define MIE_RESP_OKAY 2'h0
`define MIE_RESP_SLVERR 2'h2

// ============================================================
// Instruction word fields
`define MIE_F_OP_HI 2
`define MIE_F_OP_LO 0
`define MIE_F_DEST 3
`define MIE_F_SEL 4
`define MIE_F_MODE_HI 6
`define MIE_F_MODE_LO 5
`define MIE_F_REL 7
`define MIE_F_LIT_HI 15
`define MIE_F_LIT_LO 8
`define MIE_F_FILE_HI 14
`define MIE_F_OFS_HI 13
`define MIE_F_BANK_HI 12
`define MIE_F_LATCH_HI 14

// Mode bits: bit 0 picks decrement, bit 1 picks post
`define MIE_MODE_DEC 0
`define MIE_MODE_POST 1

// ============================================================
// Widths and addresses
`define MIE_PTR_W 16
`define MIE_BANK_W 5
`define MIE_LATCH_W 7
`define MIE_FILE_W 7
`define MIE_OFS_W 6
`define MIE_MEM_AW 8
`define MIE_MEM_DEPTH 256
`define MIE_WIN0_ADDR 7'h00
`define MIE_WIN1_ADDR 7'h01
`define MIE_STEP_INC 16'h0001
`define MIE_STEP_DEC 16'hffff

// ============================================================
// Reset values
`define MIE_ACC_RST 8'h00
`define MIE_BANK_RST 5'h00
`define MIE_LATCH_RST 7'h00
`define MIE_PTR_RST 16'h0000
`define MIE_MEMADDR_RST 8'h00

`endif

// ==== verification/mie_move_checker.sv ====
// Checker of the move block outputs against the instructions written
`timescale 1ns/1ns
`default_nettype none
`include "mie_regs.svh"
module mie_move_checker import mie_pkg::*; (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [`MIE_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic [7:0] ACC_OUT,
    input wire logic ZERO_OUT,
    input wire logic [`MIE_BANK_W-1:0] BANK_OUT,
    input wire logic [`MIE_LATCH_W-1:0] LATCH_OUT
);
    // ============================================================
    // Decode of the word taken; only joint AW+W handshakes are tracked
    wire hs = AWVALID && AWREADY && WVALID && WREADY;
    wire ins = hs && (AWADDR == `MIE_OFF_INSTR);
    wire [2:0] op = WDATA[2:0];
    wire [7:0] lit = WDATA[15:8];
    wire dst = WDATA[3];
    wire bank_ins = ins && (op == MIE_OP_LOAD_BANK);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // ============================================================
    // Executes one edge after the handshake, mirrors show it one later
    property p_resp; hs |-> ##2 BVALID; endproperty
    a_resp: assert property (p_resp) else $error("Late response");
    property p_lit; ins && op == MIE_OP_LOAD_LIT |-> ##3
        ACC_OUT == $past(lit, 3) && ZERO_OUT == $past(ZERO_OUT, 3); endproperty
    a_lit: assert property (p_lit) else $error("Bad literal");
    property p_bank; bank_ins |-> ##3 BANK_OUT == 5'($past(lit, 3))
        && ZERO_OUT == $past(ZERO_OUT, 3); endproperty
    a_bank: assert property (p_bank) else $error("Bad bank");
    property p_latch; ins && op == MIE_OP_LOAD_LATCH |-> ##3
        LATCH_OUT == 7'($past(lit, 3)) && $stable(ZERO_OUT); endproperty
    a_latch: assert property (p_latch) else $error("Bad latch");
    property p_movz; ins && op == MIE_OP_MOVE_REG && !dst |-> ##3
        ZERO_OUT == (ACC_OUT == 8'h00); endproperty
    a_movz: assert property (p_movz) else $error("Bad move flag");
    // Write-back form must leave the accumulator alone
    property p_keep; ins && op == MIE_OP_MOVE_REG && dst |-> ##3
        ACC_OUT == $past(ACC_OUT, 3); endproperty
    a_keep: assert property (p_keep) else $error("Acc changed");
    property p_indz; ins && op == MIE_OP_IND_LOAD |-> ##3
        ZERO_OUT == (ACC_OUT == 8'h00); endproperty
    a_indz: assert property (p_indz) else $error("Bad load flag");
    // Reset term covers a one-edge reset clearing the mirror
    property p_bkhold; !$stable(BANK_OUT) |-> $past(bank_ins, 3)
        || $past(SRST); endproperty
    a_bkhold: assert property (p_bkhold) else $error("Bank moved");
endmodule // mie_move_checker
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench of the data-move execution block
`timescale 1ns/1ns
`default_nettype none
`include "mie_regs.svh"
module tb_top;
    // ============================================================
    // Bus drive, design outputs, reference state
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, zero_out;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] acc_out;
    wire [4:0] bank_out;
    wire [6:0] latch_out;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 73;
    logic [7:0] mem [256]; // Reference data memory
    logic [15:0] p0 = 16'h0;
    logic [15:0] p1 = 16'h0;
    logic [7:0] acc = 8'h0;
    logic z = 1'b0;
    logic [4:0] bk = 5'h0;
    logic [6:0] lt = 7'h0;
    // Corners: preset pointer value, instruction word
    logic [31:0] corner [15] = '{32'hffff_0002, 32'h0000_0022,
        32'hffff_0052, 32'h0000_0072, 32'h0010_2082, 32'hfff0_1f92,
        32'h0000_1f03, 32'h0000_ff05, 32'h0006_0109, 32'h0000_7f09,
        32'h0000_0005, 32'h0005_0001, 32'h0000_7f01, 32'h0000_7f04,
        32'h0000_0006};
    mie_move_exec u_mie_move_exec (.CLK(clk), .SRST(srst), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .ACC_OUT(acc_out), .ZERO_OUT(zero_out), .BANK_OUT(bank_out),
        .LATCH_OUT(latch_out));
    always #50 clk = ~clk;
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            end_sim;
        end
    end
    task automatic end_sim;
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // ============================================================
    // AXI4-Lite master: hold each channel until its ready is seen
    task automatic wrchk(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask
    // ============================================================
    // Reference: access address and pointer after the indirect load
    function automatic logic [15:0] ea(input logic [15:0] p, w);
        if (w[7]) return p + {{10{w[13]}}, w[13:8]};
        if (w[6]) return p;
        return w[5] ? p - 16'h1 : p + 16'h1;
    endfunction
    function automatic logic [15:0] np(input logic [15:0] p, w);
        if (w[7]) return p;
        return w[5] ? p - 16'h1 : p + 16'h1;
    endfunction
    task automatic model(input logic [15:0] w);
        logic [15:0] a;
        a = (w[14:8] == 7'h0) ? p0 : (w[14:8] == 7'h1) ? p1 :
            {4'h0, bk, w[14:8]};
        case (w[2:0])
            3'h1: begin
                z = (mem[a[7:0]] == 8'h0);
                if (!w[3]) acc = mem[a[7:0]];
            end
            3'h2: begin
                a = ea(w[4] ? p1 : p0, w);
                acc = mem[a[7:0]];
                z = (acc == 8'h0);
                if (w[4]) p1 = np(p1, w);
                else p0 = np(p0, w);
            end
            3'h3: bk = w[12:8];
            3'h4: lt = w[14:8];
            3'h5: acc = w[15:8];
            default: ;
        endcase
    endtask
    task automatic setp(input logic [15:0] v);
        wrchk(`MIE_OFF_PTR0, {16'h0, v}, `MIE_RESP_OKAY);
        wrchk(`MIE_OFF_PTR1, {16'h0, v}, `MIE_RESP_OKAY);
        p0 = v;
        p1 = v;
    endtask
    // One instruction, then every visible result compared
    task automatic run(input logic [15:0] w);
        wrchk(`MIE_OFF_INSTR, {16'h0, w}, `MIE_RESP_OKAY);
        model(w);
        @(posedge clk);
        #1;
        chk(acc_out, acc);
        chk(zero_out, z);
        chk(bank_out, bk);
        chk(latch_out, lt);
        rdchk(`MIE_OFF_STATUS, {31'h0, z}, `MIE_RESP_OKAY);
        rdchk(`MIE_OFF_PTR0, p0, `MIE_RESP_OKAY);
        rdchk(`MIE_OFF_PTR1, p1, `MIE_RESP_OKAY);
    endtask
    initial begin
        logic [31:0] v;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdchk(8'(4 * i), 32'h0, `MIE_RESP_OKAY);
        end
        rdchk(8'h24, 32'h0, `MIE_RESP_SLVERR);
        wrchk(8'hfc, 32'h5a, `MIE_RESP_SLVERR);
        wrchk(`MIE_OFF_BANK, 32'h1f, `MIE_RESP_OKAY);
        v = $random(seed);
        wrchk(`MIE_OFF_ACC, v, `MIE_RESP_OKAY);
        acc = v[7:0];
        // Fill memory; both ends zero for the flag corners
        for (int i = 0; i < 256; i++) begin
            v = $random(seed);
            mem[i] = (i == 0 || i == 255) ? 8'h0 : v[7:0];
            wrchk(`MIE_OFF_MEMADDR, i, `MIE_RESP_OKAY);
            wrchk(`MIE_OFF_MEMDATA, {24'h0, mem[i]}, `MIE_RESP_OKAY);
        end
        foreach (corner[k]) begin
            setp(corner[k][31:16]);
            run(corner[k][15:0]);
        end
        // Random words, pointers sometimes parked at the wrap ends
        repeat (200) begin
            v = $random(seed);
            if (v[16]) setp(v[18:17] == 2'h0 ? 16'hffff :
                v[18:17] == 2'h1 ? 16'h0 : v[31:16]);
            run({v[15:3], 3'(v[2:0] % 3'h5 + 3'h1)});
        end
        // Write-back moves must leave memory as it was
        for (int i = 0; i < 256; i++) begin
            wrchk(`MIE_OFF_MEMADDR, i, `MIE_RESP_OKAY);
            rdchk(`MIE_OFF_MEMDATA, {24'h0, mem[i]}, `MIE_RESP_OKAY);
        end
        end_sim;
    end
endmodule // tb_top
bind mie_move_exec mie_move_checker u_mie_move_checker (.CLK(CLK),
    .SRST(SRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
    .ACC_OUT(ACC_OUT), .ZERO_OUT(ZERO_OUT), .BANK_OUT(BANK_OUT),
    .LATCH_OUT(LATCH_OUT));
`default_nettype wire
